// *** design/iaem_matcher.sv ***
// Added by the designer: strobed register access and the register addresses.
`timescale 1ns/1ps
module iaem_matcher (
    input  wire logic                  i_core_clk,   // System clock, 40 MHz
    input  wire logic                  i_reset_n,    // Async reset, active low
    input  wire logic                  i_clk_en,     // Freezes all state when low
    input  wire iaem_pkg::iaem_bus_s   i_bus,        // Register bus request
    output logic [iaem_pkg::DATA_W-1:0] o_rdata,     // Read data, cycle after read
    input  wire iaem_pkg::iaem_frame_s i_frame,      // Parsed header from parser
    output logic                       o_hit_valid,  // Result strobe
    output logic                       o_hit,        // Entry hit
    output logic [2:0]                 o_l4_en       // ICMP/UDP/TCP extra criteria on
);
    import iaem_pkg::*;

    iaem_state_s st_r;
    iaem_state_s st_nxt;
    logic        hit_eval;
    logic        fire;
    logic        ipv4_act;

    // Three-way criterion; reserved code never matches so a bad setting fails safe
    function automatic logic tri_ok(input iaem_tri_e sel, input logic cond);
        case (sel)
            TRI_ANY: tri_ok = 1'b1;
            TRI_NO:  tri_ok = !cond;
            TRI_YES: tri_ok = cond;
            default: tri_ok = 1'b0;
        endcase
    endfunction

    // Address filter, shared by source and destination
    function automatic logic addr_ok(input iaem_addr_e sel, input logic [31:0] frm,
                                     input logic [31:0] cfg, input logic [31:0] mask);
        case (sel)
            ADDR_ANY:  addr_ok = 1'b1;
            ADDR_HOST: addr_ok = (frm == cfg);
            ADDR_NET:  addr_ok = ((frm ^ cfg) & mask) == 32'h0000_0000;
            default:   addr_ok = 1'b0;
        endcase
    endfunction

    // Protocol selector
    function automatic logic proto_ok(input iaem_proto_e sel, input logic [7:0] prot,
                                      input logic [7:0] val);
        case (sel)
            PROTO_ANY:  proto_ok = 1'b1;
            PROTO_SPEC: proto_ok = (prot == val);
            PROTO_ICMP: proto_ok = (prot == IPPROTO_ICMP);
            PROTO_UDP:  proto_ok = (prot == IPPROTO_UDP);
            PROTO_TCP:  proto_ok = (prot == IPPROTO_TCP);
            default:    proto_ok = 1'b0;
        endcase
    endfunction

    // Extra-criteria enables follow the protocol selector
    function automatic logic [2:0] l4_calc(input iaem_proto_e sel);
        logic [2:0] v;
        v = 3'h0;
        v[L4_ICMP] = (sel == PROTO_ICMP);
        v[L4_UDP]  = (sel == PROTO_UDP);
        v[L4_TCP]  = (sel == PROTO_TCP);
        l4_calc = v;
    endfunction

    // A frame offered while the clock enable is low is not taken; the parser must hold it
    assign fire     = i_clk_en && i_frame.valid;
    assign ipv4_act = fire && st_r.ctrl.ipv4_sel;

    // Match decision for the frame presented this cycle
    always_comb begin
        if (!st_r.ctrl.ipv4_sel) begin
            hit_eval = 1'b1;
        end else begin
            hit_eval = i_frame.is_ipv4
                && proto_ok(st_r.ctrl.proto_sel, i_frame.proto, st_r.proto_val)
                && tri_ok(st_r.ctrl.ttl_sel, i_frame.ttl != 8'h00)
                && tri_ok(st_r.ctrl.frag_sel,
                          i_frame.more_frag || (i_frame.frag_off != 13'h0000))
                && tri_ok(st_r.ctrl.opt_sel, i_frame.has_opts)
                && addr_ok(st_r.ctrl.src_sel, i_frame.src, st_r.src_addr,
                           st_r.src_mask)
                && addr_ok(st_r.ctrl.dst_sel, i_frame.dst, st_r.dst_addr,
                           st_r.dst_mask);
        end
    end

    // Next state: register writes, read mux, result pipeline
    always_comb begin
        st_nxt = st_r;
        st_nxt.rdata = 32'h0000_0000;
        // Register writes; unmapped offsets change nothing
        if (i_bus.wr) begin
            case (i_bus.addr)
                OFS_CTRL:     st_nxt.ctrl = iaem_ctrl_s'(i_bus.wdata[CTRL_W-1:0]);
                OFS_PROTO:    st_nxt.proto_val = i_bus.wdata[7:0];
                OFS_SRC_ADDR: st_nxt.src_addr = i_bus.wdata;
                OFS_SRC_MASK: st_nxt.src_mask = i_bus.wdata;
                OFS_DST_ADDR: st_nxt.dst_addr = i_bus.wdata;
                OFS_DST_MASK: st_nxt.dst_mask = i_bus.wdata;
                OFS_STATUS:   st_nxt.hit_cnt = {CNT_W{1'b0}};
                default:      st_nxt.hit_cnt = st_r.hit_cnt;
            endcase
        end
        // Read mux; narrow registers read back zero-filled
        if (i_bus.rd) begin
            case (i_bus.addr)
                OFS_CTRL:     st_nxt.rdata = {{(DATA_W-CTRL_W){1'b0}}, st_r.ctrl};
                OFS_PROTO:    st_nxt.rdata = {24'h00_0000, st_r.proto_val};
                OFS_SRC_ADDR: st_nxt.rdata = st_r.src_addr;
                OFS_SRC_MASK: st_nxt.rdata = st_r.src_mask;
                OFS_DST_ADDR: st_nxt.rdata = st_r.dst_addr;
                OFS_DST_MASK: st_nxt.rdata = st_r.dst_mask;
                OFS_STATUS: begin
                    st_nxt.rdata[STAT_HIT_BIT] = st_r.hit;
                    st_nxt.rdata[STAT_VALID_BIT] = st_r.hit_valid;
                    st_nxt.rdata[STAT_CNT_LSB +: CNT_W] = st_r.hit_cnt;
                end
                default:      st_nxt.rdata = 32'h0000_0000;
            endcase
        end
        // Result holds between frames so software can inspect the last decision
        st_nxt.hit_valid = fire;
        if (fire) begin
            st_nxt.hit = hit_eval;
            st_nxt.l4_en = st_r.ctrl.ipv4_sel ? l4_calc(st_r.ctrl.proto_sel) : 3'h0;
            // A hit in the same cycle as a counter clear restarts the count at one
            if (hit_eval) begin
                st_nxt.hit_cnt = (i_bus.wr && i_bus.addr == OFS_STATUS) ?
                                 {{(CNT_W-1){1'b0}}, 1'b1} : CNT_W'(st_r.hit_cnt + 1'b1);
            end
        end
    end

    // State register; clock enable gates every bit including read data
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            st_r           <= '0;
            st_r.ctrl      <= iaem_ctrl_s'(RST_CTRL);
            st_r.proto_val <= RST_PROTO;
            st_r.src_addr  <= RST_ADDR;
            st_r.src_mask  <= RST_MASK;
            st_r.dst_addr  <= RST_ADDR;
            st_r.dst_mask  <= RST_MASK;
        end else if (i_clk_en) begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from the state register
    assign o_rdata     = st_r.rdata;
    assign o_hit_valid = st_r.hit_valid;
    assign o_hit       = st_r.hit;
    assign o_l4_en     = st_r.l4_en;

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_reset_n);

    // A taken frame yields a strobed reject or accept on the next edge
    sequence s_reject;
        ##1 (o_hit_valid && !o_hit);
    endsequence

    sequence s_accept;
        ##1 (o_hit_valid && o_hit);
    endsequence

    non_ipv4_rej_a: assert property (ipv4_act && !i_frame.is_ipv4 |-> s_reject)
        else $error("non-IPv4 frame hit an IPv4 entry");

    no_ipv4_sel_a: assert property (fire && !st_r.ctrl.ipv4_sel |-> s_accept)
        else $error("entry without IPv4 selection missed");

    all_any_a: assert property (ipv4_act && i_frame.is_ipv4
        && st_r.ctrl.proto_sel == PROTO_ANY && st_r.ctrl.ttl_sel == TRI_ANY
        && st_r.ctrl.frag_sel == TRI_ANY && st_r.ctrl.opt_sel == TRI_ANY
        && st_r.ctrl.src_sel == ADDR_ANY && st_r.ctrl.dst_sel == ADDR_ANY |-> s_accept)
        else $error("all don't-care entry missed an IPv4 frame");

    proto_spec_a: assert property (ipv4_act && st_r.ctrl.proto_sel == PROTO_SPEC
        && i_frame.proto != st_r.proto_val |-> s_reject)
        else $error("specific protocol mismatch hit");

    icmp_rej_a: assert property (ipv4_act && st_r.ctrl.proto_sel == PROTO_ICMP
        && i_frame.proto != 8'h01 |-> s_reject)
        else $error("ICMP selector hit non-ICMP frame");

    udp_tcp_rej_a: assert property (ipv4_act
        && ((st_r.ctrl.proto_sel == PROTO_UDP && i_frame.proto != 8'h11)
         || (st_r.ctrl.proto_sel == PROTO_TCP && i_frame.proto != 8'h06)) |-> s_reject)
        else $error("UDP or TCP selector hit wrong protocol");

    l4_icmp_a: assert property (ipv4_act && st_r.ctrl.proto_sel == PROTO_ICMP
        |=> o_l4_en == 3'b001)
        else $error("ICMP extra criteria not enabled");

    l4_udp_a: assert property (ipv4_act && st_r.ctrl.proto_sel == PROTO_UDP
        |=> o_l4_en == 3'b010)
        else $error("UDP extra criteria not enabled");

    l4_tcp_a: assert property (ipv4_act && st_r.ctrl.proto_sel == PROTO_TCP
        |=> o_l4_en == 3'b100)
        else $error("TCP extra criteria not enabled");

    ttl_check_a: assert property (ipv4_act
        && ((st_r.ctrl.ttl_sel == TRI_NO && i_frame.ttl != 8'h00)
        || (st_r.ctrl.ttl_sel == TRI_YES && i_frame.ttl == 8'h00)) |-> s_reject)
        else $error("TTL criterion not enforced");

    frag_check_a: assert property (ipv4_act && ((st_r.ctrl.frag_sel == TRI_NO
        && (i_frame.more_frag || i_frame.frag_off != 13'h0000))
        || (st_r.ctrl.frag_sel == TRI_YES && !i_frame.more_frag
        && i_frame.frag_off == 13'h0000)) |-> s_reject)
        else $error("fragment criterion not enforced");

    opt_check_a: assert property (ipv4_act && ((st_r.ctrl.opt_sel == TRI_NO && i_frame.has_opts)
        || (st_r.ctrl.opt_sel == TRI_YES && !i_frame.has_opts)) |-> s_reject)
        else $error("options criterion not enforced");

    src_host_a: assert property (ipv4_act && st_r.ctrl.src_sel == ADDR_HOST
        && i_frame.src != st_r.src_addr |-> s_reject)
        else $error("source host mismatch hit");

    src_net_a: assert property (ipv4_act && st_r.ctrl.src_sel == ADDR_NET
        && ((i_frame.src ^ st_r.src_addr) & st_r.src_mask) != 32'h0 |-> s_reject)
        else $error("source network mismatch hit");

    dst_host_a: assert property (ipv4_act && st_r.ctrl.dst_sel == ADDR_HOST
        && i_frame.dst != st_r.dst_addr |-> s_reject)
        else $error("destination host mismatch hit");

    dst_net_a: assert property (ipv4_act && st_r.ctrl.dst_sel == ADDR_NET
        && ((i_frame.dst ^ st_r.dst_addr) & st_r.dst_mask) != 32'h0 |-> s_reject)
        else $error("destination network mismatch hit");

    read_once_a: assert property (i_clk_en && !i_bus.rd ##1 i_clk_en |-> o_rdata == 32'h0)
        else $error("read data outside the answer cycle");

    // Entries that do not select IPv4 never turn on the extra criteria
    no_ipv4_l4_a: assert property (fire && !st_r.ctrl.ipv4_sel
        |=> o_l4_en == 3'b000)
        else $error("extra criteria on for a non-IPv4 entry");

    // Any and specific selectors leave the extra criteria off
    l4_off_a: assert property (ipv4_act
        && (st_r.ctrl.proto_sel == PROTO_ANY || st_r.ctrl.proto_sel == PROTO_SPEC)
        |=> o_l4_en == 3'b000)
        else $error("extra criteria on without ICMP, UDP or TCP selector");

    // The strobe lasts one cycle and the decision holds until the next frame
    hit_hold_a: assert property (i_clk_en && !i_frame.valid
        |=> !o_hit_valid && $stable(o_hit) && $stable(o_l4_en))
        else $error("result changed without a frame");

    // A low clock enable freezes every output, read data included
    en_freeze_a: assert property (!i_clk_en
        |=> $stable(o_hit_valid) && $stable(o_hit) && $stable(o_l4_en) && $stable(o_rdata))
        else $error("state moved while the clock enable was low");

    // Hit counter: one step per hit, wraps at its width, cleared by a status write
    cnt_step_a: assert property (fire && hit_eval
        && !(i_bus.wr && i_bus.addr == OFS_STATUS)
        |=> st_r.hit_cnt == CNT_W'($past(st_r.hit_cnt) + 1'b1))
        else $error("hit count did not advance");

    cnt_clear_a: assert property (i_clk_en && i_bus.wr && i_bus.addr == OFS_STATUS
        && !(fire && hit_eval) |=> st_r.hit_cnt == {CNT_W{1'b0}})
        else $error("status write did not clear the hit count");

    // A hit beside a clear is not lost: the count restarts at one
    cnt_hit_wins_a: assert property (fire && hit_eval && i_bus.wr && i_bus.addr == OFS_STATUS
        |=> st_r.hit_cnt == {{(CNT_W-1){1'b0}}, 1'b1})
        else $error("hit lost against a count clear");

    // Read data follow the register one cycle after the read strobe
    rd_proto_a: assert property (i_clk_en && i_bus.rd && i_bus.addr == OFS_PROTO
        |=> o_rdata == {24'h00_0000, $past(st_r.proto_val)})
        else $error("protocol value read back wrong");

    rd_ctrl_a: assert property (i_clk_en && i_bus.rd && i_bus.addr == OFS_CTRL
        |=> o_rdata == {{(DATA_W-CTRL_W){1'b0}}, $past(st_r.ctrl)})
        else $error("control word read back wrong");

    // Offsets past the status word answer with zero
    rd_unmapped_a: assert property (i_clk_en && i_bus.rd && i_bus.addr > OFS_STATUS
        |=> o_rdata == 32'h0000_0000)
        else $error("unmapped read returned data");

endmodule

// *** inc/iaem_pkg.sv ***
package iaem_pkg;

    // Register bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_PROTO    = 8'h04;
    localparam logic [7:0] OFS_SRC_ADDR = 8'h08;
    localparam logic [7:0] OFS_SRC_MASK = 8'h0c;
    localparam logic [7:0] OFS_DST_ADDR = 8'h10;
    localparam logic [7:0] OFS_DST_MASK = 8'h14;
    localparam logic [7:0] OFS_STATUS   = 8'h18;

    // Field widths and positions
    localparam int CTRL_W         = 14;
    localparam int STAT_HIT_BIT   = 0;
    localparam int STAT_VALID_BIT = 1;
    localparam int STAT_CNT_LSB   = 16;
    localparam int CNT_W          = 16;

    // Reset values
    localparam logic [31:0] RST_ADDR = 32'h0000_0000;
    localparam logic [31:0] RST_MASK = 32'hffff_ffff;
    localparam logic [7:0]  RST_PROTO = 8'h00;

    // Standard IPv4 protocol numbers
    localparam logic [7:0] IPPROTO_ICMP = 8'h01;
    localparam logic [7:0] IPPROTO_TCP  = 8'h06;
    localparam logic [7:0] IPPROTO_UDP  = 8'h11;

    // Extra-criteria enable bit positions
    localparam int L4_ICMP = 0;
    localparam int L4_UDP  = 1;
    localparam int L4_TCP  = 2;

    typedef enum logic [2:0] {PROTO_ANY, PROTO_SPEC, PROTO_ICMP, PROTO_UDP, PROTO_TCP} iaem_proto_e;
    typedef enum logic [1:0] {TRI_ANY, TRI_NO, TRI_YES, TRI_RSVD} iaem_tri_e;
    typedef enum logic [1:0] {ADDR_ANY, ADDR_HOST, ADDR_NET, ADDR_RSVD} iaem_addr_e;

    // Control register layout, bit 0 upward: ipv4_sel, proto, ttl, frag, opt, src, dst
    typedef struct packed {
        iaem_addr_e  dst_sel;
        iaem_addr_e  src_sel;
        iaem_tri_e   opt_sel;
        iaem_tri_e   frag_sel;
        iaem_tri_e   ttl_sel;
        iaem_proto_e proto_sel;
        logic        ipv4_sel;
    } iaem_ctrl_s;

    localparam logic [CTRL_W-1:0] RST_CTRL = 14'h0000;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } iaem_bus_s;

    typedef struct packed {
        logic        valid;
        logic        is_ipv4;
        logic [7:0]  proto;
        logic [7:0]  ttl;
        logic        more_frag;
        logic [12:0] frag_off;
        logic        has_opts;
        logic [31:0] src;
        logic [31:0] dst;
    } iaem_frame_s;

    typedef struct packed {
        iaem_ctrl_s       ctrl;
        logic [7:0]       proto_val;
        logic [31:0]      src_addr;
        logic [31:0]      src_mask;
        logic [31:0]      dst_addr;
        logic [31:0]      dst_mask;
        logic [31:0]      rdata;
        logic             hit_valid;
        logic             hit;
        logic [2:0]       l4_en;
        logic [CNT_W-1:0] hit_cnt;
    } iaem_state_s;

endpackage

// *** sim/iaem_parser_model.sv ***
`timescale 1ns/1ps
// Stand-in for the frame parser: one header per request, a cycle later
module iaem_parser_model (
    input  wire logic                  i_core_clk, // System clock
    input  wire logic                  i_reset_n,  // Async reset, active low
    input  wire logic                  i_send,     // Emit i_hdr next cycle
    input  wire iaem_pkg::iaem_frame_s i_hdr,      // Header to emit
    output iaem_pkg::iaem_frame_s      o_frame     // Toward the matcher
);
    import iaem_pkg::*;

    // Between frames the fields churn, so stale values never pass for a frame
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_frame <= '0;
        end else if (i_send) begin
            o_frame       <= i_hdr;
            o_frame.valid <= 1'b1;
        end else begin
            o_frame       <= ~o_frame;
            o_frame.valid <= 1'b0;
        end
    end
endmodule

// *** sim/ipv4_acl_entry_matcher_tb_top.sv ***
`timescale 1ns/1ps
module ipv4_acl_entry_matcher_tb_top;
    import iaem_pkg::*;
    logic        i_core_clk;
    logic        i_reset_n;
    logic        clk_en;
    iaem_bus_s   bus;
    iaem_frame_s hdr;
    iaem_frame_s frame;
    logic        send;
    logic [31:0] rdata;
    logic        hit_valid;
    logic        hit;
    logic [2:0]  l4_en;
    logic [31:0] seed = 32'h3b620478;
    logic [31:0] cfg [7];
    logic [3:0]  exp_hit [$];
    logic [31:0] exp_rd [$];
    logic        rd_d = 1'b0;
    logic [15:0] hits;
    logic        lhit;
    int          fails;
    int          compares;

    iaem_matcher u_iaem_matcher (
        .i_core_clk  (i_core_clk),
        .i_reset_n   (i_reset_n),
        .i_clk_en    (clk_en),
        .i_bus       (bus),
        .o_rdata     (rdata),
        .i_frame     (frame),
        .o_hit_valid (hit_valid),
        .o_hit       (hit),
        .o_l4_en     (l4_en)
    );
    iaem_parser_model u_iaem_parser_model (
        .i_core_clk (i_core_clk),
        .i_reset_n  (i_reset_n),
        .i_send     (send),
        .i_hdr      (hdr),
        .o_frame    (frame)
    );

    initial begin
        i_core_clk = 1'b0;
        forever #12.5 i_core_clk = ~i_core_clk;
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Three-way setting: 0 any, 1 flag must be clear, 2 flag must be set
    function automatic logic tri_ok(logic [1:0] s, logic fl);
        return s == 2'd0 || (s == 2'd1 && !fl) || (s == 2'd2 && fl);
    endfunction

    function automatic logic adr_ok(logic [1:0] s, logic [31:0] a, logic [31:0] m,
                                    logic [31:0] v);
        return s == 2'd0 || (s == 2'd1 && v == a) || (s == 2'd2 && ((v ^ a) & m) == 0);
    endfunction

    // Reference decision from the shadow registers
    function automatic logic [3:0] exp_of(iaem_frame_s f);
        iaem_ctrl_s c;
        logic       pok;
        logic       ok;
        c = cfg[0][13:0];
        case (c.proto_sel)
            PROTO_ANY:  pok = 1'b1;
            PROTO_SPEC: pok = f.proto == cfg[1][7:0];
            PROTO_ICMP: pok = f.proto == 8'h01;
            PROTO_UDP:  pok = f.proto == 8'h11;
            PROTO_TCP:  pok = f.proto == 8'h06;
            default:    pok = 1'b0;
        endcase
        ok = f.is_ipv4 && pok && tri_ok(c.ttl_sel, f.ttl != 0)
            && tri_ok(c.frag_sel, f.more_frag || f.frag_off != 0)
            && tri_ok(c.opt_sel, f.has_opts)
            && adr_ok(c.src_sel, cfg[2], cfg[3], f.src)
            && adr_ok(c.dst_sel, cfg[4], cfg[5], f.dst);
        if (!c.ipv4_sel) begin
            return 4'b0001;
        end
        return {c.proto_sel == PROTO_TCP, c.proto_sel == PROTO_UDP,
                c.proto_sel == PROTO_ICMP, ok};
    endfunction

    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic test_done();
        if (fails == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Bus write; shadow keeps only the implemented bits
    task automatic wr(logic [7:0] a, logic [31:0] d);
        bus  <= '{a, d, 1'b1, 1'b0};
        send <= 1'b0;
        if (a < 8'h18) begin
            cfg[a[4:2]] = d & (a == 8'h00 ? 32'h3fff : a == 8'h04 ? 32'hff : 32'hffffffff);
        end
        if (a == 8'h18) begin
            hits = 16'h0;
        end
        @(posedge i_core_clk);
    endtask

    task automatic rd(logic [7:0] a);
        bus  <= '{a, rnd(), 1'b0, 1'b1};
        send <= 1'b0;
        exp_rd.push_back(a > 8'h18 ? 32'h0 : a == 8'h18 ? {hits, 15'h0, lhit} : cfg[a[4:2]]);
        @(posedge i_core_clk);
    endtask

    task automatic fr(iaem_frame_s f);
        logic [3:0] e;
        e = exp_of(f);
        bus.wr <= 1'b0;
        bus.rd <= 1'b0;
        send   <= 1'b1;
        hdr    <= f;
        exp_hit.push_back(e);
        hits += 16'(e[0]);
        lhit = e[0];
        @(posedge i_core_clk);
    endtask

    task automatic idle(int n);
        bus.wr <= 1'b0;
        bus.rd <= 1'b0;
        send   <= 1'b0;
        repeat (n) @(posedge i_core_clk);
    endtask

    // Watcher: each result strobe takes the oldest note; rdata is zero off-read
    always @(posedge i_core_clk) begin
        rd_d <= bus.rd && clk_en;
        if (hit_valid === 1'b1) begin
            if (exp_hit.size() == 0) begin
                check("hit_extra", 32'h1, 32'h0);
            end else begin
                check("hit_l4_en", {l4_en, hit}, exp_hit.pop_front());
            end
        end
        if (rd_d) begin
            check("rdata", rdata, exp_rd.pop_front());
        end else if (i_reset_n) begin
            check("rdata_idle", rdata, 32'h0);
        end
    end

    initial begin
        #(25 * 80000);
        fails++;
        test_done();
    end

    initial begin
        iaem_frame_s f;
        logic [31:0] v;
        logic [31:0] r;
        i_reset_n = 1'b0;
        clk_en    = 1'b1;
        bus       = '0;
        hdr       = '0;
        send      = 1'b0;
        fails     = 0;
        compares  = 0;
        hits      = 16'h0;
        lhit      = 1'b0;
        cfg = '{32'h0, 32'h0, 32'h0, 32'hffffffff, 32'h0, 32'hffffffff, 32'h0};
        repeat (4) @(posedge i_core_clk);
        i_reset_n <= 1'b1;
        // Reset values after an unmapped write, then the unmapped word itself
        wr(8'h1c, 32'hffffffff);
        for (int a = 0; a <= 'h1c; a += 4) begin
            rd(8'(a));
        end
        // Upper bits of narrow registers read as zero
        wr(OFS_CTRL, 32'hffffffff);
        wr(OFS_PROTO, 32'hffffffff);
        rd(OFS_CTRL);
        rd(OFS_PROTO);
        // Let the read answer pass first, since a low enable freezes it
        idle(1);
        // A strobe with the clock enable low is ignored
        clk_en <= 1'b0;
        bus    <= '{OFS_SRC_ADDR, 32'h5a5a5a5a, 1'b1, 1'b0};
        @(posedge i_core_clk);
        clk_en <= 1'b1;
        idle(2);
        rd(OFS_SRC_ADDR);
        // Random entries, four back-to-back frames each, biased toward near-misses
        for (int i = 0; i < 400; i++) begin
            v = 32'({2'(rnd() % 3), 2'(rnd() % 3), 2'(rnd() % 3), 2'(rnd() % 3),
                     2'(rnd() % 3), 3'(rnd() % 5), rnd() % 4 != 0});
            if (i % 16 == 0) begin
                v = rnd();
            end
            wr(OFS_CTRL, v);
            for (int k = 1; k < 6; k++) begin
                wr(8'(k * 4), rnd());
            end
            for (int k = 0; k < 4; k++) begin
                r = rnd();
                f = '0;
                f.is_ipv4   = r[0] | r[1];
                f.proto     = r[3:2] == 2'd3 ? cfg[1][7:0] : r[3:2] == 2'd2 ? 8'h11
                            : r[3:2] == 2'd1 ? 8'h06 : 8'h01 + 8'(r[4]);
                f.ttl       = r[5] ? 8'h00 : (r[6] ? 8'h01 : r[14:7]);
                f.more_frag = r[15] & r[16];
                f.frag_off  = r[17] ? 13'h0 : 13'h1 << r[21:18];
                f.has_opts  = r[22];
                f.src       = cfg[2] ^ (r[23] ? 32'h0 : 32'h1 << r[28:24]);
                f.dst       = cfg[4] ^ (r[29] ? 32'h0 : 32'h1 << r[4:0]);
                fr(f);
            end
            idle(2);
            if (i % 32 == 0) begin
                idle(3);
                rd(OFS_STATUS);
                wr(OFS_STATUS, rnd());
                // Clear lands on the edge that takes this frame; a hit restarts the count at one
                fr(f);
                wr(OFS_STATUS, rnd());
                hits = 16'(lhit);
            end
        end
        idle(5);
        for (int t = 0; t < 20 && exp_hit.size() + exp_rd.size() > 0; t++) begin
            @(posedge i_core_clk);
        end
        if (exp_hit.size() + exp_rd.size() > 0) begin
            fails++;
        end
        test_done();
    end
endmodule
